// File: design/crs_top.sv
// How it works
// - Watchdog reset stays internal; the clear pin is never driven low.
// - Internal clear option ignores the clear pin, treating it as high.
// - Power-on source holds reset until supply-adequate indication rises.
// - Enabled brown-out detector holds reset while supply stays low.
// - Power-on source ignores falling supply; only brown-out reacts.
// - Power-up delay lasts 72 ms, only after power-on or brown-out.
// - Reset holds while power-up delay runs on its own RC oscillator.
// - Power-up delay disable bit: 1 disables the delay, 0 enables.
// - After power-up delay, count 1024 oscillator input cycles.
// - Start-up count only in crystal modes, on power-on or wake.
// - Clear pin path filters out pulses shorter than a minimum width.
// - Watchdog wake from sleep resumes without resetting anything.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "crs_map.svh"
`default_nettype none

module crs_top (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus
  input wire crs_pkg::crs_axi_req_t axi_req,
  output var crs_pkg::crs_axi_rsp_t axi_rsp,
  // Pins and supply monitors, asynchronous
  input wire logic master_clear_pin,
  output var logic master_clear_pin_o,
  output var logic master_clear_pin_oe,
  input wire logic supply_up,
  input wire logic brownout_low,
  input wire logic osc_input_pin,
  input wire logic rc_osc,
  // Watchdog and sleep, same clock
  input wire logic watchdog_timeout,
  input wire logic sleep_active,
  // Configuration fuses, same clock
  input wire logic [7:0] cfg_fuses,
  // Chip control
  output var logic chip_reset_n,
  output var logic cpu_hold
);
  import crs_pkg::*;

  // ========================================================
  // Derived counts
  localparam int CLR_MIN_CYC =
    (`CRS_CLEAR_MIN_NS + `CRS_CLK_PERIOD_NS - 1) / `CRS_CLK_PERIOD_NS;
  localparam int DELAY_TICKS =
    (`CRS_DELAY_TIME_US * 1000 + `CRS_RC_PERIOD_NS - 1) / `CRS_RC_PERIOD_NS;
  localparam logic [5:0] CLR_MIN = 6'(CLR_MIN_CYC);
  localparam logic [10:0] DELAY_LAST = 11'(DELAY_TICKS - 1);
  localparam logic [10:0] START_LAST = 11'(`CRS_START_CYCLES - 1);

  function automatic logic is_xtal(input logic [7:0] cfg);
    logic [2:0] m;
    m = cfg[`CRS_CFG_OSC_LSB +: 3];
    return (m == `CRS_OSC_LOWPWR) || (m == `CRS_OSC_MID) ||
           (m == `CRS_OSC_FAST);
  endfunction

  function automatic logic addr_mapped(input logic [15:0] a);
    return (a == `CRS_ADDR_STATE) || (a == `CRS_ADDR_CAUSE) ||
           (a == `CRS_ADDR_CFG);
  endfunction

  // ========================================================
  // Pin synchronisers: 0 clear, 1 supply, 2 brown-out, 3 osc, 4 rc
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic osc_d_r;
  logic rc_d_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 5'h01;
      sync2_r <= 5'h01;
      osc_d_r <= 1'b0;
      rc_d_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= {rc_osc, osc_input_pin, brownout_low, supply_up,
                  master_clear_pin};
      sync2_r <= sync1_r;
      osc_d_r <= sync2_r[3];
      rc_d_r <= sync2_r[4];
    end
  end

  wire osc_rise = sync2_r[3] & ~osc_d_r;
  wire rc_rise = sync2_r[4] & ~rc_d_r;

  // ========================================================
  // Clear pin glitch filter
  logic [5:0] clr_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_cnt_r <= 6'h00;
    end else if (ce) begin
      if (sync2_r[0]) begin
        clr_cnt_r <= 6'h00;
      end else if (clr_cnt_r != CLR_MIN) begin
        clr_cnt_r <= clr_cnt_r + 6'h01;
      end
    end
  end

  // Low for the whole minimum width before it counts
  wire clr_act = (clr_cnt_r == CLR_MIN);

  // ========================================================
  // Reset sources
  logic [7:0] cfg_r;
  logic por_active_r;
  logic delay_pend_r;
  logic start_pend_r;
  crs_state_t state_r;
  crs_state_t state_nxt;

  wire clr_src = clr_act & ~cfg_r[`CRS_CFG_CLEAR_INT];
  wire brown_src = cfg_r[`CRS_CFG_BROWN_EN] & sync2_r[2];
  wire wdog_rst = watchdog_timeout & ~sleep_active;
  wire wdog_wake = watchdog_timeout & sleep_active;
  wire src_any = por_active_r | brown_src | clr_src | wdog_rst;
  wire xtal = is_xtal(cfg_r);
  wire delay_go = delay_pend_r & ~cfg_r[`CRS_CFG_DELAY_DIS];
  wire start_go = start_pend_r & xtal;
  wire enter_run = (state_nxt == ST_RUN) && (state_r != ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `CRS_CFG_RESET;
      por_active_r <= 1'b1;
      delay_pend_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_SRC) begin
        cfg_r <= cfg_fuses;
      end
      // Cleared once; a falling supply never sets it again
      if (sync2_r[1]) begin
        por_active_r <= 1'b0;
      end
      // Set wins over the clear at entry to run
      delay_pend_r <= (delay_pend_r & ~enter_run) | por_active_r |
                      brown_src;
      start_pend_r <= (start_pend_r & ~enter_run) | por_active_r;
    end
  end

  // ========================================================
  // Sequencer
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic in_reset_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ST_SRC: begin
        if (delay_go) begin
          state_nxt = ST_DELAY;
        end else if (start_go) begin
          state_nxt = ST_START;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_DELAY: begin
        if (rc_rise) begin
          if (cnt_r == DELAY_LAST) begin
            cnt_nxt = 11'h000;
            state_nxt = start_go ? ST_START : ST_RUN;
          end else begin
            cnt_nxt = cnt_r + 11'h001;
          end
        end
      end
      ST_START: begin
        if (osc_rise) begin
          if (cnt_r == START_LAST) begin
            cnt_nxt = 11'h000;
            state_nxt = ST_RUN;
          end else begin
            cnt_nxt = cnt_r + 11'h001;
          end
        end
      end
      ST_RUN: begin
        // In crystal modes, wake holds the core for the start-up count, no reset
        if (wdog_wake && xtal) begin
          state_nxt = ST_START;
        end
      end
    endcase
    if (src_any) begin
      state_nxt = ST_SRC;
      cnt_nxt = 11'h000;
    end
  end

  wire in_reset_nxt = src_any | (in_reset_r & ~enter_run);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_SRC;
      cnt_r <= 11'h000;
      in_reset_r <= 1'b1;
      chip_reset_n <= 1'b0;
      cpu_hold <= 1'b1;
      master_clear_pin_o <= 1'b0;
      master_clear_pin_oe <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      in_reset_r <= in_reset_nxt;
      chip_reset_n <= ~in_reset_nxt;
      cpu_hold <= (state_nxt != ST_RUN);
      // Pin is input only; a watchdog reset never reaches it
      master_clear_pin_oe <= 1'b0;
    end
  end

  // ========================================================
  // Reset cause flags
  logic [3:0] cause_r;
  logic aw_have_r;
  logic w_have_r;
  logic [15:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  wire wr_go = aw_have_r & w_have_r & ~axi_rsp.bvalid;
  wire wr_cause = wr_go & (aw_addr_r == `CRS_ADDR_CAUSE) & w_strb_r[0];
  wire [3:0] cause_clr = wr_cause ? w_data_r[3:0] : 4'h0;
  wire [3:0] cause_set = {wdog_rst, clr_src, brown_src, por_active_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= `CRS_CAUSE_RESET;
    end else if (ce) begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // ========================================================
  // AXI4-Lite slave, one write and one read at a time
  wire aw_fire = axi_req.awvalid & axi_rsp.awready;
  wire w_fire = axi_req.wvalid & axi_rsp.wready;
  wire b_fire = axi_rsp.bvalid & axi_req.bready;
  wire ar_fire = axi_req.arvalid & axi_rsp.arready;
  wire r_fire = axi_rsp.rvalid & axi_req.rready;
  wire [31:0] state_word = {26'h0, brown_src, clr_act, por_active_r,
                            in_reset_r, state_r};
  wire [31:0] rd_word =
    (axi_req.araddr == `CRS_ADDR_STATE) ? state_word :
    (axi_req.araddr == `CRS_ADDR_CAUSE) ? {28'h0, cause_r} :
    (axi_req.araddr == `CRS_ADDR_CFG) ? {24'h0, cfg_r} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 16'h0000;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      axi_rsp <= '0;
      axi_rsp.awready <= 1'b1;
      axi_rsp.wready <= 1'b1;
      axi_rsp.arready <= 1'b1;
    end else if (ce) begin
      if (aw_fire) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end
      if (w_fire) begin
        w_have_r <= 1'b1;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
        axi_rsp.wready <= 1'b0;
      end
      if (wr_go) begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_fire) begin
        axi_rsp.bvalid <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        axi_rsp.awready <= 1'b1;
        axi_rsp.wready <= 1'b1;
      end
      if (ar_fire) begin
        axi_rsp.arready <= 1'b0;
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rdata <= rd_word;
        axi_rsp.rresp <= addr_mapped(axi_req.araddr) ? RESP_OKAY :
                         RESP_SLVERR;
      end
      if (r_fire) begin
        axi_rsp.rvalid <= 1'b0;
        axi_rsp.arready <= 1'b1;
      end
    end
  end

  // ========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PIN_NEVER_DRIVEN: assert property (
    wdog_rst |=> !master_clear_pin_oe
  ) else $error("clear pin driven during watchdog reset");

  AST_INTERNAL_CLEAR: assert property (
    (ce && state_r == ST_RUN && cfg_r[`CRS_CFG_CLEAR_INT] &&
     !por_active_r && !brown_src && !watchdog_timeout) |=> state_r == ST_RUN
  ) else $error("clear pin acted while internal option set");

  AST_POR_HOLD: assert property (
    (ce && por_active_r) |=> !chip_reset_n && state_r == ST_SRC
  ) else $error("released while supply not yet adequate");

  AST_BOD_HOLD: assert property (
    (ce && brown_src) |=> !chip_reset_n ##0 cause_r[`CRS_CAUSE_BROWN]
  ) else $error("brown-out did not hold reset");

  AST_POR_ONCE: assert property (
    !por_active_r |=> !por_active_r
  ) else $error("power-on source re-armed");

  AST_DELAY_CAUSE: assert property (
    $rose(state_r == ST_DELAY) |-> $past(delay_pend_r)
  ) else $error("power-up delay started without power cause");

  AST_DELAY_RESET: assert property (
    (state_r == ST_DELAY) |-> in_reset_r
  ) else $error("reset released during power-up delay");

  AST_DELAY_DISABLED: assert property (
    (ce && state_r == ST_SRC && !src_any && cfg_r[`CRS_CFG_DELAY_DIS])
    |=> state_r != ST_DELAY
  ) else $error("power-up delay ran while disabled");

  AST_START_COUNT: assert property (
    (ce && state_r == ST_START && !src_any && state_nxt == ST_RUN)
    |-> cnt_r == START_LAST && osc_rise
  ) else $error("start-up count ended early");

  AST_START_MODE: assert property (
    $rose(state_r == ST_START) |-> $past(xtal)
  ) else $error("start-up count outside crystal modes");

  AST_FILTER_RESTART: assert property (
    (ce && sync2_r[0]) |=> clr_cnt_r == 6'h00 ##1 !clr_act
  ) else $error("clear filter did not restart on high pin");

  AST_WAKE_NO_RESET: assert property (
    (ce && state_r == ST_RUN && wdog_wake && !por_active_r &&
     !brown_src && !clr_src) |=> chip_reset_n
  ) else $error("watchdog wake caused a reset");

  AST_SOURCE_OR: assert property (
    (ce && src_any) |=> !chip_reset_n && cpu_hold
  ) else $error("active source did not assert chip reset");

endmodule

`default_nettype wire

// File: design/crs_map.svh
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// ==========================================================
// Register map (byte addresses, AXI4-Lite, 32-bit words)
`define CRS_ADDR_STATE 16'h0000
`define CRS_ADDR_CAUSE 16'h0004
`define CRS_CFG_INDEX 16'h2007
`define CRS_ADDR_CFG 16'h801c

// ==========================================================
// Configuration word fields and reset value
`define CRS_CFG_BROWN_EN 6
`define CRS_CFG_CLEAR_INT 5
`define CRS_CFG_DELAY_DIS 4
`define CRS_CFG_OSC_LSB 0
`define CRS_CFG_RESET 8'hff
`define CRS_OSC_LOWPWR 3'h0
`define CRS_OSC_MID 3'h1
`define CRS_OSC_FAST 3'h2

// ==========================================================
// Cause flag positions and reset value
`define CRS_CAUSE_POR 0
`define CRS_CAUSE_BROWN 1
`define CRS_CAUSE_CLEAR 2
`define CRS_CAUSE_WDOG 3
`define CRS_CAUSE_RESET 4'h0

// ==========================================================
// Timing
`define CRS_CLK_PERIOD_NS 40
`define CRS_DELAY_TIME_US 72000
`define CRS_RC_PERIOD_NS 70313
`define CRS_START_CYCLES 1024
`define CRS_CLEAR_MIN_NS 2000

`endif

// File: design/crs_pkg.sv
package crs_pkg;

  // ========================================================
  // Bus carriers
  typedef struct packed {
    logic [15:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [15:0] araddr;
    logic arvalid;
    logic rready;
  } crs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crs_axi_rsp_t;

  // ========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_SRC,
    ST_DELAY,
    ST_START,
    ST_RUN
  } crs_state_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } crs_resp_t;

endpackage

// File: tb/crs_partner.sv
`timescale 1ns/1ps
`default_nettype none

module crs_partner #(
  parameter int RC_NS = 330,
  parameter int OSC_NS = 170
) (
  // Bench commands
  input wire logic supply_ok,
  input wire logic sag,
  input wire logic clear_low,
  // Pins
  input wire logic pin_o,
  input wire logic pin_oe,
  output var logic master_clear_pin,
  output var logic supply_up,
  output var logic brownout_low,
  output var logic osc_input_pin,
  output var logic rc_osc
);
  // ========================================================
  // Oscillators
  // Run free, phase unrelated to aclk; faster than silicon so
  // the run stays short
  initial begin
    rc_osc = 1'b0;
    forever #(RC_NS / 2.0) rc_osc = ~rc_osc;
  end
  initial begin
    osc_input_pin = 1'b0;
    #7;
    forever #(OSC_NS / 2.0) osc_input_pin = ~osc_input_pin;
  end
  // ========================================================
  // Pins
  // Pull-up holds the pin high unless pressed or driven low
  assign master_clear_pin = ~clear_low & ~(pin_oe & ~pin_o);
  assign supply_up = supply_ok;
  assign brownout_low = sag;
endmodule

`default_nettype wire

// File: tb/crs_top_bench.sv
`timescale 1ns/1ps
`include "crs_map.svh"
`default_nettype none

module crs_top_bench;
  import crs_pkg::*;
  localparam int RC_NS = 330;
  localparam int OSC_NS = 170;
  localparam int DELAY_CYC = 1024 * RC_NS / 40;
  localparam int START_CYC = 1024 * OSC_NS / 40;
  logic aclk, aresetn, ce, wdog, sleep, pin_o, pin_oe, rst_n, hold;
  logic supply_ok, sag, clear_low, clr_pin, sup, sag_pin, osc, rc;
  logic drove = 1'b0;
  logic [7:0] cfg;
  logic [31:0] rd;
  logic [1:0] resp;
  crs_axi_req_t req;
  crs_axi_rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  crs_top crs_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .master_clear_pin(clr_pin),
    .master_clear_pin_o(pin_o), .master_clear_pin_oe(pin_oe),
    .supply_up(sup), .brownout_low(sag_pin), .osc_input_pin(osc),
    .rc_osc(rc), .watchdog_timeout(wdog), .sleep_active(sleep),
    .cfg_fuses(cfg), .chip_reset_n(rst_n), .cpu_hold(hold));
  crs_partner #(.RC_NS(RC_NS), .OSC_NS(OSC_NS)) crs_partner_inst (
    .supply_ok(supply_ok), .sag(sag), .clear_low(clear_low),
    .pin_o(pin_o), .pin_oe(pin_oe), .master_clear_pin(clr_pin),
    .supply_up(sup), .brownout_low(sag_pin), .osc_input_pin(osc),
    .rc_osc(rc));

  // ========================================================
  // Clock, timeout, pin watch
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (aresetn && (pin_oe !== 1'b0 || pin_o !== 1'b0)) drove <= 1'b1;
    if (cycles == 70000) begin
      n_errors++;
      $display("CHECK FAILED timeout exp done got hang");
      stop_test();
    end
  end

  // ========================================================
  // Helpers
  task automatic stop_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic chk_rng(string w, int lo, int hi, int g);
    comparisons++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", w, lo, hi, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(logic [15:0] a, logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    // Let an edge pass before the next request
    step(1);
  endtask
  task automatic rd_chk(string w, logic [15:0] a, logic [31:0] m,
                        logic [31:0] e);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    chk(w, e, rd & m);
    step(1);
  endtask
  // Counts cycles until the core runs again
  task automatic wait_run(output int n);
    n = 0;
    while ({hold, rst_n} !== 2'b01) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic power_on(logic [7:0] c, int lo, int hi);
    int n;
    cfg <= c;
    supply_ok <= 1'b0;
    aresetn <= 1'b0;
    step(10);
    aresetn <= 1'b1;
    step(40);
    chk("held before supply", 32'h2, {hold, rst_n});
    supply_ok <= 1'b1;
    wait_run(n);
    chk_rng("power-up time", lo, hi, n);
  endtask
  // Reloads the fuse copy by passing through a watchdog reset
  task automatic kick(logic [7:0] c);
    int n;
    cfg <= c;
    wdog_pulse();
    step(4);
    wait_run(n);
  endtask
  task automatic wdog_pulse();
    wdog <= 1'b1;
    step(1);
    wdog <= 1'b0;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_power();
    power_on(8'h01, DELAY_CYC + START_CYC - 15,
             DELAY_CYC + START_CYC + 30);
    rd_chk("cause", `CRS_ADDR_CAUSE, 32'hf, 32'h1);
    rd_chk("config", `CRS_ADDR_CFG, 32'hffffffff, 32'h1);
    axi_wr(`CRS_ADDR_CFG, 32'haa);
    chk("ro write resp", 32'h0, {30'h0, resp});
    rd_chk("config ro", `CRS_ADDR_CFG, 32'hffffffff, 32'h1);
    rd_chk("unmapped data", 16'h0010, 32'hffffffff, 32'h0);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    supply_ok <= 1'b0;
    step(100);
    chk("supply fall", 32'h1, {hold, rst_n});
    supply_ok <= 1'b1;
  endtask
  task automatic t_wdt();
    int n;
    axi_wr(`CRS_ADDR_CAUSE, 32'hf);
    chk("cause write resp", 32'h0, {30'h0, resp});
    // Enable low freezes everything, so a watchdog event is lost
    ce <= 1'b0;
    wdog <= 1'b1;
    step(2);
    wdog <= 1'b0;
    step(1);
    ce <= 1'b1;
    step(3);
    chk("frozen by enable", 32'h1, {31'h0, rst_n});
    wdog_pulse();
    step(1);
    chk("watchdog reset", 32'h0, {31'h0, rst_n});
    wait_run(n);
    chk_rng("watchdog release", 0, 20, n);
    chk("pin never driven", 32'h0, {31'h0, drove});
    rd_chk("watchdog cause", `CRS_ADDR_CAUSE, 32'hf, 32'h8);
    axi_wr(`CRS_ADDR_CAUSE, 32'h8);
    rd_chk("cause cleared", `CRS_ADDR_CAUSE, 32'hf, 32'h0);
  endtask
  task automatic t_clear();
    int n;
    clear_low <= 1'b1;
    step(20);
    clear_low <= 1'b0;
    step(10);
    chk("short clear", 32'h1, {31'h0, rst_n});
    clear_low <= 1'b1;
    step(100);
    chk("long clear", 32'h0, {31'h0, rst_n});
    clear_low <= 1'b0;
    wait_run(n);
    chk_rng("clear release", 0, 60, n);
    kick(8'h21);
    clear_low <= 1'b1;
    step(100);
    chk("internal clear", 32'h1, {31'h0, rst_n});
    clear_low <= 1'b0;
  endtask
  task automatic t_brown();
    int n;
    kick(8'h41);
    sag <= 1'b1;
    step(300);
    chk("brown-out hold", 32'h0, {31'h0, rst_n});
    rd_chk("state sag", `CRS_ADDR_STATE, 32'h3f, 32'h24);
    sag <= 1'b0;
    step(20);
    rd_chk("state delay", `CRS_ADDR_STATE, 32'h7, 32'h5);
    wait_run(n);
    chk_rng("brown-out time", DELAY_CYC - 40, DELAY_CYC + 20,
            n);
  endtask
  task automatic t_nodelay();
    for (int m = 0; m < 3; m++) begin
      power_on(8'h10 | m[7:0], START_CYC - 15,
               START_CYC + 30);
    end
    power_on(8'h17, 0, 20);
  endtask
  task automatic t_wake();
    int n;
    sleep <= 1'b1;
    wdog_pulse();
    step(6);
    chk("plain wake", 32'h1, {hold, rst_n});
    sleep <= 1'b0;
    kick(8'h11);
    sleep <= 1'b1;
    wdog_pulse();
    step(6);
    chk("crystal wake", 32'h3, {hold, rst_n});
    wait_run(n);
    chk_rng("wake time", START_CYC - 20, START_CYC + 30, n);
    sleep <= 1'b0;
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    wdog = 1'b0;
    sleep = 1'b0;
    cfg = 8'h01;
    supply_ok = 1'b0;
    sag = 1'b0;
    clear_low = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    t_power();
    t_wdt();
    t_clear();
    t_brown();
    t_nodelay();
    t_wake();
    stop_test();
  end
endmodule

`default_nettype wire
